// ### rtl/emsm_serial_mux.sv
// Connector multiplexer between the standard serial controller and the
// management controller's emergency port, with escape and password logic.
// Assumes power, self-test, watchdog and controller signals are on core_clk.
`timescale 1ns/1ns
module emsm_serial_mux import emsm_pkg::*; #(
  parameter int BIT_CYCLES = BIT_CYC
) (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic [ADDR_W-1:0] reg_addr,
  input wire logic [DATA_W-1:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [DATA_W-1:0] reg_rdata,
  input wire logic sys_power_on,
  input wire logic sys_post_active,
  input wire logic wdt_expire,
  input wire logic conn_rxd,
  output logic conn_txd,
  input wire logic conn_dcd_n,
  input wire logic conn_cts_n,
  output logic conn_dtr_n,
  output logic conn_rts_n,
  input wire logic std_txd,
  input wire logic std_dtr_n,
  input wire logic std_rts_n,
  output logic std_rxd,
  input wire logic mc_txd,
  output logic mc_rxd,
  input wire logic [2:0] svc_req,
  output logic [2:0] svc_grant,
  output logic video_hold
);
  localparam int CW = $clog2(BIT_CYCLES + 1);
  localparam int NS = 6;

  // Pin synchronisers; stage one feeds only stage two
  logic [NS-1:0] sync1_q, sync2_q;
  always_ff @(posedge core_clk) begin
    sync1_q <= {conn_rxd, conn_dcd_n, conn_cts_n, std_txd, std_dtr_n, std_rts_n};
    sync2_q <= sync1_q;
  end
  logic rxd_s, dcd_n_s, cts_n_s, std_txd_s, std_dtr_n_s, std_rts_n_s;
  assign {rxd_s, dcd_n_s, cts_n_s, std_txd_s, std_dtr_n_s, std_rts_n_s} = sync2_q;

  // Register file
  logic [7:0] ctrl_q, ctrl_d, modem_q, modem_d, rdata_q, rdata_d;
  logic [7:0] pw_q [PW_LEN];
  logic [7:0] pw_d [PW_LEN];
  logic pw_wr, cmd_std, cmd_emp;
  emsm_mode_t mode;
  logic pw_en, redir_cfg, hs_cd;
  logic route_q, route_d, unlock_q, unlock_d, ract_q, ract_d, pwr_q;

  assign mode = emsm_mode_t'(ctrl_q[F_MODE +: 2]); // R1
  assign pw_en = ctrl_q[F_PW_EN]; // R1
  assign redir_cfg = ctrl_q[F_REDIR];
  assign hs_cd = ctrl_q[F_HS_CD];
  assign cmd_std = reg_wr && reg_addr == OFF_CMD && reg_wdata == CMD_TO_STD;
  assign cmd_emp = reg_wr && reg_addr == OFF_CMD && reg_wdata == CMD_TO_EMP;
  assign pw_wr = reg_wr && reg_addr[2] == OFF_PW[2];

  always_comb begin
    ctrl_d = ctrl_q;
    modem_d = modem_q;
    pw_d = pw_q;
    rdata_d = 8'h00;
    if (reg_wr && reg_addr == OFF_CTRL) begin
      ctrl_d = reg_wdata; // R8
    end
    if (reg_wr && reg_addr == OFF_MODEM) begin
      modem_d = reg_wdata; // R13
    end
    if (pw_wr) begin
      pw_d[reg_addr[1:0]] = reg_wdata; // R8
    end
    if (reg_rd) begin
      case (reg_addr)
        OFF_CTRL: rdata_d = ctrl_q;
        OFF_MODEM: rdata_d = modem_q;
        OFF_STAT: rdata_d = {4'h0, ~dcd_n_s, ract_q, unlock_q, route_q};
        default: rdata_d = 8'h00;
      endcase
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      ctrl_q <= RST_CTRL;
      modem_q <= RST_MODEM;
      rdata_q <= 8'h00;
      for (int i = 0; i < PW_LEN; i++) begin
        pw_q[i] <= RST_PW;
      end
    end else begin
      ctrl_q <= ctrl_d;
      modem_q <= modem_d;
      rdata_q <= rdata_d;
      pw_q <= pw_d;
    end
  end
  assign reg_rdata = rdata_q;

  // Receiver for the connector line, fixed 19200 N,8,1
  emsm_rx_t rx_st_q, rx_st_d;
  logic [CW-1:0] rx_cnt_q, rx_cnt_d;
  logic [2:0] rx_bit_q, rx_bit_d;
  logic [7:0] rx_sh_q, rx_sh_d;
  logic rx_vld_q, rx_vld_d;

  always_comb begin
    rx_st_d = rx_st_q;
    rx_cnt_d = rx_cnt_q;
    rx_bit_d = rx_bit_q;
    rx_sh_d = rx_sh_q;
    rx_vld_d = 1'b0;
    if (rx_cnt_q != '0) begin
      rx_cnt_d = rx_cnt_q - 1'b1;
    end
    case (rx_st_q)
      RX_IDLE: begin
        if (!rxd_s) begin
          rx_st_d = RX_START;
          rx_cnt_d = CW'(BIT_CYCLES / 2); // R12
        end
      end
      RX_START: begin
        if (rx_cnt_q == '0) begin
          rx_st_d = rxd_s ? RX_IDLE : RX_DATA;
          rx_cnt_d = CW'(BIT_CYCLES - 1); // R6
          rx_bit_d = 3'h0;
        end
      end
      RX_DATA: begin
        if (rx_cnt_q == '0) begin
          rx_sh_d = {rxd_s, rx_sh_q[7:1]};
          rx_cnt_d = CW'(BIT_CYCLES - 1);
          rx_bit_d = rx_bit_q + 3'h1;
          if (rx_bit_q == 3'h7) begin
            rx_st_d = RX_STOP; // R12
          end
        end
      end
      RX_STOP: begin
        if (rx_cnt_q == '0) begin
          // Framing error drops the character
          rx_vld_d = rxd_s;
          rx_st_d = RX_IDLE;
        end
      end
      default: rx_st_d = RX_IDLE;
    endcase
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      rx_st_q <= RX_IDLE;
      rx_cnt_q <= '0;
      rx_bit_q <= 3'h0;
      rx_sh_q <= 8'h00;
      rx_vld_q <= 1'b0;
    end else begin
      rx_st_q <= rx_st_d;
      rx_cnt_q <= rx_cnt_d;
      rx_bit_q <= rx_bit_d;
      rx_sh_q <= rx_sh_d;
      rx_vld_q <= rx_vld_d;
    end
  end

  // Sequence matchers; a breaking character may itself start a new match
  function automatic logic [2:0] step(input logic [2:0] idx, input logic [7:0] ch,
                                      input logic [7:0] want, input logic [7:0] first);
    if (ch == want) begin
      return idx + 3'h1;
    end
    return (ch == first) ? 3'h1 : 3'h0;
  endfunction

  logic [2:0] esc_idx_q, esc_idx_d, cdz_idx_q, cdz_idx_d, pw_idx_q, pw_idx_d;
  logic [7:0] esc_want, cdz_want;
  logic esc_hit, cdz0_hit, cdz1_hit, pw_hit, esc_ok;

  always_comb begin
    case (esc_idx_q)
      3'h0: esc_want = CH_ESC;
      3'h1: esc_want = CH_O;
      default: esc_want = CH_9;
    endcase
    case (cdz_idx_q)
      3'h0: cdz_want = CH_ESC;
      3'h1: cdz_want = CH_C;
      3'h2: cdz_want = CH_D;
      default: cdz_want = CH_Z;
    endcase
  end

  // Escape only counts while redirection owns the second port
  assign esc_ok = redir_cfg && ract_q && (mode == EMSM_PRE || mode == EMSM_ALW); // R10
  assign esc_hit = rx_vld_q && esc_idx_q == 3'h2 && rx_sh_q == CH_9 && esc_ok; // R9 R17
  assign cdz0_hit = rx_vld_q && cdz_idx_q == 3'h4 && rx_sh_q == CH_0; // R15
  assign cdz1_hit = rx_vld_q && cdz_idx_q == 3'h4 && rx_sh_q == CH_1; // R15
  assign pw_hit = rx_vld_q && route_q && pw_idx_q == 3'(PW_LEN - 1)
                  && rx_sh_q == pw_q[PW_LEN-1]; // R7

  always_comb begin
    esc_idx_d = esc_idx_q;
    cdz_idx_d = cdz_idx_q;
    pw_idx_d = pw_idx_q;
    if (rx_vld_q) begin
      esc_idx_d = step(esc_idx_q, rx_sh_q, esc_want, CH_ESC); // R17
      if (esc_idx_d == 3'h3) begin
        esc_idx_d = 3'h0;
      end
      if (cdz_idx_q == 3'h4) begin
        cdz_idx_d = (rx_sh_q == CH_ESC) ? 3'h1 : 3'h0;
      end else begin
        cdz_idx_d = step(cdz_idx_q, rx_sh_q, cdz_want, CH_ESC);
      end
      if (route_q) begin
        pw_idx_d = step(pw_idx_q, rx_sh_q, pw_q[pw_idx_q[1:0]], pw_q[0]); // R7
        if (pw_idx_d == 3'(PW_LEN)) begin
          pw_idx_d = 3'h0;
        end
      end
    end
    if (pw_wr) begin
      pw_idx_d = 3'h0;
    end
  end

  // Routing state; any switch-to-emergency event wins over a switch back
  always_comb begin
    route_d = route_q;
    case (mode)
      EMSM_PRE: begin
        if (!sys_power_on || cmd_emp || esc_hit || wdt_expire) begin
          route_d = 1'b1; // R3 R5 R9 R11
        end else if (sys_power_on && !pwr_q) begin
          route_d = 1'b1; // R3
        end else if (cmd_std) begin
          route_d = 1'b0; // R4
        end
      end
      EMSM_ALW: route_d = 1'b1; // R6
      default: route_d = 1'b0; // R2
    endcase
    unlock_d = unlock_q;
    if (pw_wr) begin
      unlock_d = 1'b0;
    end
    if (pw_hit) begin
      unlock_d = 1'b1; // R7
    end
    ract_d = ract_q;
    if (cdz0_hit) begin
      ract_d = 1'b0; // R15
    end else if (cdz1_hit) begin
      ract_d = 1'b1; // R15
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      esc_idx_q <= 3'h0;
      cdz_idx_q <= 3'h0;
      pw_idx_q <= 3'h0;
      route_q <= 1'b0;
      unlock_q <= 1'b0;
      ract_q <= RST_RACT;
      pwr_q <= 1'b0;
    end else begin
      esc_idx_q <= esc_idx_d;
      cdz_idx_q <= cdz_idx_d;
      pw_idx_q <= pw_idx_d;
      route_q <= route_d;
      unlock_q <= unlock_d;
      ract_q <= ract_d;
      pwr_q <= sys_power_on;
    end
  end

  // Pin drivers, registered; service grants combinational
  logic txd_q, std_rxd_q, mc_rxd_q, dtr_n_q, rts_n_q, vhold_q;
  always_ff @(posedge core_clk) begin
    if (rst) begin
      txd_q <= 1'b1;
      std_rxd_q <= 1'b1;
      mc_rxd_q <= 1'b1;
      dtr_n_q <= 1'b1;
      rts_n_q <= 1'b1;
      vhold_q <= 1'b0;
    end else begin
      txd_q <= route_q ? mc_txd : std_txd_s; // R9
      std_rxd_q <= route_q ? 1'b1 : rxd_s; // R2
      mc_rxd_q <= route_q ? rxd_s : 1'b1;
      dtr_n_q <= route_q ? ~modem_q[F_DTR] : std_dtr_n_s; // R13
      rts_n_q <= route_q ? ~modem_q[F_RTS] : std_rts_n_s; // R13
      vhold_q <= hs_cd && (dcd_n_s || cts_n_s); // R14
    end
  end
  assign conn_txd = txd_q;
  assign std_rxd = std_rxd_q;
  assign mc_rxd = mc_rxd_q;
  assign conn_dtr_n = dtr_n_q;
  assign conn_rts_n = rts_n_q;
  assign video_hold = vhold_q;
  assign svc_grant = svc_req & {3{!pw_en || unlock_q}}; // R7

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (rst);

  a_dis_keeps_std: assert property (mode == EMSM_DIS |=> !route_q) // R2
    else $error("disabled mode routed to controller");
  a_alw_keeps_emp: assert property (mode == EMSM_ALW |=> route_q) // R6
    else $error("always mode not on controller");
  a_pre_standby_emp: assert property (mode == EMSM_PRE && !sys_power_on |=> route_q) // R3
    else $error("standby not on controller");
  a_cmd_to_std: assert property (mode == EMSM_PRE && cmd_std && pwr_q && sys_power_on // R4
      && !cmd_emp && !esc_hit && !wdt_expire |=> !route_q)
    else $error("handover command ignored");
  a_cmd_to_emp: assert property (mode == EMSM_PRE && cmd_emp |=> route_q) // R5
    else $error("switch back command ignored");
  a_wdt_to_emp: assert property (mode == EMSM_PRE && wdt_expire |=> route_q // R11
      ##1 txd_q == $past(mc_txd))
    else $error("watchdog did not switch port");
  a_esc_full_seq: assert property (mode == EMSM_PRE && !route_q && sys_power_on // R10 R17
      && pwr_q && (!esc_ok || esc_idx_q != 3'h2) && !cmd_emp && !wdt_expire |=> !route_q)
    else $error("escape acted without gate");
  a_esc_routes: assert property (esc_hit |=> route_q ##1 txd_q == $past(mc_txd)) // R9
    else $error("escape did not route connector");
  a_pw_blocks: assert property (pw_en && !unlock_q |-> svc_grant == 3'h0) // R7
    else $error("service granted while locked");
  a_cd_hold: assert property (hs_cd && dcd_n_s && !$changed(hs_cd) |=> video_hold) // R14
    else $error("video sent without carrier");
  a_cdz_toggle: assert property (cdz0_hit |=> !ract_q ##0 !esc_ok) // R15
    else $error("redirection not released");

  c_escape_switch: cover property (mode == EMSM_PRE && !route_q ##1 esc_hit ##1 route_q);
  c_unlock: cover property (pw_en && !unlock_q ##1 unlock_q);
  c_handover: cover property (mode == EMSM_PRE && route_q && cmd_std ##1 !route_q);
  c_wdt: cover property (mode == EMSM_PRE && !route_q && wdt_expire);
endmodule // emsm_serial_mux

// ### common/emsm_pkg.sv
// Constants and types for the emergency serial port connector multiplexer.
// Assumes a 125 MHz core clock and an 8-bit register port with 3 address bits.
// Function
// [R1] Four settings: disabled, pre-boot only, always active, plus password security.
// [R2] Disabled: connector stays on the standard serial controller, never the controller.
// [R3] Pre-boot: connector on management controller during self test and standby; code takes self test only from the power-on edge, sys_post_active unused.
// [R4] Host command before OS handover switches the connector to the standard controller.
// [R5] Host commands at any time switch the connector back to the emergency port.
// [R6] Always active: connector permanently on management controller port at 19200 baud.
// [R7] With password set, power, reset and NMI services blocked until password received.
// [R8] Host downloads password and mode over the ISA-side interface on setup save.
// [R9] Received ESC 'O' '9' routes connector to controller, standard data ignored.
// [R10] Escape honoured only with redirection on second port and mode always/pre-boot.
// [R11] Watchdog timeout during failed self test switches connector to the emergency port.
// [R12] Shared with redirection: 19200 baud, no parity, 8 data bits, 1 stop bit.
// [R13] Management controller drives attached modem using host-supplied modem settings.
// [R14] With CTS/RTS plus carrier detect, video updates withheld without carrier.
// [R15] Esc-CDZ0 disables redirection releasing port; Esc-CDZ1 restarts it, reclaiming it.
// [R16] Host reaches the controller command interface at ISA I/O 0CA0 through 0CA3.
// [R17] Escape detector restarts on out-of-order character, acts only on full sequence.
package emsm_pkg;
  localparam int CLK_HZ = 125_000_000;
  localparam int BAUD = 19200;
  localparam int BIT_CYC = CLK_HZ / BAUD;
  localparam int ADDR_W = 3;
  localparam int DATA_W = 8;
  localparam int PW_LEN = 4;
  localparam logic [2:0] OFF_CTRL = 3'h0;
  localparam logic [2:0] OFF_CMD = 3'h1;
  localparam logic [2:0] OFF_MODEM = 3'h2;
  localparam logic [2:0] OFF_STAT = 3'h3;
  localparam logic [2:0] OFF_PW = 3'h4;
  localparam int F_MODE = 0;
  localparam int F_PW_EN = 2;
  localparam int F_REDIR = 3;
  localparam int F_HS_CD = 4;
  localparam int F_DTR = 0;
  localparam int F_RTS = 1;
  localparam int F_ROUTE = 0;
  localparam int F_UNLOCK = 1;
  localparam int F_RACT = 2;
  localparam int F_DCD = 3;
  localparam logic [7:0] RST_CTRL = 8'h00;
  localparam logic [7:0] RST_MODEM = 8'h00;
  localparam logic [7:0] RST_PW = 8'h00;
  localparam logic RST_RACT = 1'b1;
  localparam logic [7:0] CMD_TO_STD = 8'h01;
  localparam logic [7:0] CMD_TO_EMP = 8'h02;
  localparam logic [7:0] CH_ESC = 8'h1B;
  localparam logic [7:0] CH_O = 8'h4F;
  localparam logic [7:0] CH_9 = 8'h39;
  localparam logic [7:0] CH_C = 8'h43;
  localparam logic [7:0] CH_D = 8'h44;
  localparam logic [7:0] CH_Z = 8'h5A;
  localparam logic [7:0] CH_0 = 8'h30;
  localparam logic [7:0] CH_1 = 8'h31;
  typedef enum logic [1:0] {
    EMSM_DIS = 2'h0, EMSM_PRE = 2'h1, EMSM_ALW = 2'h2, EMSM_RSV = 2'h3
  } emsm_mode_t;
  typedef enum logic [1:0] {
    RX_IDLE = 2'h0, RX_START = 2'h1, RX_DATA = 2'h3, RX_STOP = 2'h2
  } emsm_rx_t;
endpackage

// ### verification/emsm_term.sv
// Remote terminal model on the connector receive pin.
// Assumes the bench shares core_clk and uses the same bit period as the mux.
`timescale 1ns/1ns
module emsm_term #(
  parameter int BIT_CYCLES = 16
) (
  input wire logic core_clk,
  output logic conn_rxd
);
  // Line idles at mark between characters
  initial conn_rxd = 1'b1;
  task automatic send(input logic [7:0] ch);
    logic [9:0] frame;
    frame = {1'b1, ch, 1'b0};
    for (int i = 0; i < 10; i++) begin
      conn_rxd <= frame[i];
      repeat (BIT_CYCLES) @(posedge core_clk);
    end
  endtask
  task automatic set_line(input logic v);
    conn_rxd <= v;
  endtask
endmodule // emsm_term

// ### verification/emsm_serial_mux_test.sv
// Self-checking bench for the serial connector multiplexer.
// Assumes one 125 MHz clock and the terminal model on the receive pin.
`timescale 1ns/1ns
module emsm_serial_mux_test;
  import emsm_pkg::*;
  localparam int BITS = 16;
  logic core_clk = 1'b0;
  logic rst = 1'b1;
  logic [ADDR_W-1:0] reg_addr = '0;
  logic [DATA_W-1:0] reg_wdata = '0;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [DATA_W-1:0] reg_rdata;
  logic sys_power_on = 1'b0;
  logic wdt_expire = 1'b0;
  logic conn_rxd, conn_txd, conn_dtr_n, conn_rts_n, std_rxd, mc_rxd, video_hold;
  logic conn_dcd_n = 1'b1;
  logic conn_cts_n = 1'b0;
  logic std_txd = 1'b1;
  logic mc_txd = 1'b1;
  logic [2:0] svc_req = 3'h7;
  logic [2:0] svc_grant;
  logic [7:0] rv;
  int mismatches = 0;
  int num_checks = 0;
  int cyc = 0;

  emsm_serial_mux #(.BIT_CYCLES(BITS)) i_emsm_serial_mux (
    .core_clk, .rst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
    .sys_power_on, .sys_post_active(1'b0), .wdt_expire, .conn_rxd, .conn_txd,
    .conn_dcd_n, .conn_cts_n, .conn_dtr_n, .conn_rts_n, .std_txd,
    .std_dtr_n(1'b1), .std_rts_n(1'b1), .std_rxd, .mc_txd, .mc_rxd,
    .svc_req, .svc_grant, .video_hold
  );
  emsm_term #(.BIT_CYCLES(BITS)) i_emsm_term (.core_clk, .conn_rxd);

  always #4 core_clk = ~core_clk;

  task automatic end_sim;
    $display("checks %0d mismatches %0d", num_checks, mismatches);
    if (mismatches == 0 && num_checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  // Whole run needs well under 15000 cycles
  always @(posedge core_clk) begin
    cyc++;
    if (cyc == 15000) begin
      mismatches++;
      end_sim();
    end
  end

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    num_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("[FAIL] %0t seen %h expected %h", $time, got, exp);
    end
  endtask

  // Extra cycles let route and data outputs follow the write
  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    @(posedge core_clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge core_clk);
    reg_wr <= 1'b0;
    repeat (3) @(posedge core_clk);
  endtask

  task automatic rd(input logic [2:0] a, output logic [7:0] d);
    @(posedge core_clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge core_clk);
    reg_rd <= 1'b0;
    @(posedge core_clk);
    d = reg_rdata;
  endtask

  task automatic stat(input logic [7:0] mask, input logic [7:0] exp);
    logic [7:0] s;
    rd(OFF_STAT, s);
    chk(s & mask, exp);
  endtask

  // Sends n characters, first one in the top byte
  task automatic snd(input logic [39:0] s, input int n);
    for (int i = 0; i < n; i++) begin
      i_emsm_term.send(s[39-8*i -: 8]);
    end
    repeat (6) @(posedge core_clk);
  endtask

  task automatic wdt_pulse;
    @(posedge core_clk);
    wdt_expire <= 1'b1;
    @(posedge core_clk);
    wdt_expire <= 1'b0;
    repeat (3) @(posedge core_clk);
  endtask

  // Low pulse shorter than half a bit: shows the routing, yields no character
  task automatic rx_low(input logic [1:0] exp);
    i_emsm_term.set_line(1'b0);
    repeat (4) @(posedge core_clk);
    chk(8'({std_rxd, mc_rxd}), 8'(exp));
    i_emsm_term.set_line(1'b1);
    repeat (12) @(posedge core_clk);
  endtask

  initial begin
    repeat (6) @(posedge core_clk);
    rst <= 1'b0;
    stat(8'h0F, 8'h04);
    rd(OFF_CTRL, rv);
    chk(rv, RST_CTRL);
    // Standby power: every mode code, reserved one included
    for (int m = 0; m < 4; m++) begin
      wr(OFF_CTRL, 8'(m));
      rd(OFF_CTRL, rv);
      chk(rv, 8'(m));
      stat(8'h01, (m == 1 || m == 2) ? 8'h01 : 8'h00);
    end
    wr(OFF_CTRL, 8'h08);
    wr(OFF_CMD, CMD_TO_EMP);
    wdt_pulse();
    snd({CH_ESC, CH_O, CH_9, 16'h0000}, 3);
    stat(8'h01, 8'h00);
    std_txd <= 1'b0;
    repeat (4) @(posedge core_clk);
    chk(8'(conn_txd), 8'h00);
    chk(8'(mc_rxd), 8'h01);
    rx_low(2'b01);
    wr(OFF_CTRL, 8'h09);
    stat(8'h01, 8'h01);
    sys_power_on <= 1'b1;
    repeat (4) @(posedge core_clk);
    stat(8'h01, 8'h01);
    wr(OFF_CMD, CMD_TO_STD);
    stat(8'h01, 8'h00);
    chk(8'(conn_txd), 8'h00);
    wr(OFF_CMD, CMD_TO_EMP);
    stat(8'h01, 8'h01);
    chk(8'(conn_txd), 8'(mc_txd));
    chk(8'(std_rxd), 8'h01);
    rx_low(2'b10);
    wr(OFF_CMD, CMD_TO_STD);
    wdt_pulse();
    stat(8'h01, 8'h01);
    wr(OFF_CMD, CMD_TO_STD);
    snd({CH_ESC, CH_O, 8'h38, 16'h0000}, 3);
    stat(8'h01, 8'h00);
    snd({CH_ESC, CH_O, CH_ESC, CH_O, CH_9}, 5);
    stat(8'h01, 8'h01);
    std_txd <= 1'b1;
    mc_txd <= 1'b0;
    repeat (4) @(posedge core_clk);
    chk(8'(conn_txd), 8'h00);
    mc_txd <= 1'b1;
    wr(OFF_CMD, CMD_TO_STD);
    wr(OFF_CTRL, 8'h01);
    snd({CH_ESC, CH_O, CH_9, 16'h0000}, 3);
    stat(8'h01, 8'h00);
    // Host download of password and mode
    wr(OFF_CTRL, 8'h06);
    for (int i = 0; i < PW_LEN; i++) begin
      wr(OFF_PW + 3'(i), 8'h45 + 8'(i));
    end
    stat(8'h03, 8'h01);
    chk(8'(svc_grant), 8'h00);
    snd({8'h58, 8'h45, 8'h46, 8'h47, 8'h00}, 4);
    chk(8'(svc_grant), 8'h00);
    snd({8'h45, 8'h46, 8'h47, 8'h48, 8'h00}, 4);
    chk(8'(svc_grant), 8'h07);
    stat(8'h02, 8'h02);
    wr(OFF_CMD, CMD_TO_STD);
    stat(8'h01, 8'h01);
    wr(OFF_MODEM, 8'h03);
    chk(8'({conn_dtr_n, conn_rts_n}), 8'h00);
    wr(OFF_CTRL, 8'h12);
    repeat (4) @(posedge core_clk);
    chk(8'(video_hold), 8'h01);
    conn_dcd_n <= 1'b0;
    repeat (6) @(posedge core_clk);
    chk(8'(video_hold), 8'h00);
    stat(8'h08, 8'h08);
    snd({CH_ESC, CH_C, CH_D, CH_Z, CH_0}, 5);
    stat(8'h04, 8'h00);
    snd({CH_ESC, CH_C, CH_D, CH_Z, CH_1}, 5);
    stat(8'h04, 8'h04);
    rd(OFF_CMD, rv);
    chk(rv, 8'h00);
    end_sim();
  end
endmodule // emsm_serial_mux_test
